// ### hdl/aogc_pkg.sv
// Purpose: shared constants for converter offset and gain correction
// Assumes: 32-bit register port, byte offsets in steps of four
// Notes:   coefficient reset values and mode codes are top-level parameters
package aogc_pkg;
   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned DATA_W    = 24;
   localparam int unsigned COEF_W    = 16;
   localparam int unsigned RES_W     = 16;
   localparam int unsigned MODE_W    = 3;
   localparam int unsigned CH_W      = 2;
   localparam int unsigned SF_W      = 7;
   localparam int unsigned FLT_W     = 16;
   localparam int unsigned MAX_CH    = 4;
   //////////////////////////////////////////////////////////////////////////////
   localparam logic [7:0]  REG_MODE   = 8'h00;
   localparam logic [7:0]  REG_FILTER = 8'h04;
   localparam logic [7:0]  REG_FLAGS  = 8'h08;
   localparam logic [7:0]  REG_RESULT = 8'h10;
   localparam logic [7:0]  REG_OFFSET = 8'h20;
   localparam logic [7:0]  REG_GAIN   = 8'h30;
   localparam logic [7:0]  REG_STRIDE = 8'h04;
   //////////////////////////////////////////////////////////////////////////////
   localparam int unsigned CAL_CHAN_LSB  = 4;
   localparam int unsigned FLT_CHOP_BIT  = 15;
   localparam int unsigned FLT_OBIN_BIT  = 14;
   localparam int unsigned FLAG_BUSY_BIT = 8;
   localparam logic [MODE_W-1:0] MODE_RST   = 3'h0;
   localparam logic [FLT_W-1:0]  FILTER_RST = 16'h0000;
   //////////////////////////////////////////////////////////////////////////////
   localparam logic [COEF_W-1:0] GAIN_SAT        = 16'hffff;
   localparam int unsigned       GAIN_FRAC       = 14;
   localparam int unsigned       OFFSET_SHIFT    = 8;
   localparam int unsigned       ROUND_SHIFT     = 22;
   localparam logic [DATA_W-1:0] FULL_SCALE_CODE = 24'h7fffff;
   localparam logic [2:0]        PERIODS_CHOP    = 3'h2;
   localparam logic [2:0]        PERIODS_NOCHOP  = 3'h3;
   localparam logic [1:0] INSEL_EXT  = 2'h0;
   localparam logic [1:0] INSEL_ZERO = 2'h1;
   localparam logic [1:0] INSEL_FULL = 2'h2;
   typedef enum logic [1:0] {
      CAL_IDLE = 2'b00,
      CAL_MEAS = 2'b01,
      CAL_DIV  = 2'b10
   } aogc_cal_e;
endpackage

// ### hdl/aogc_corrector.sv
// Purpose: chop averaging, offset removal, gain scaling, rounding, clamping
// Assumes: one filtered word per valid pulse, channel index below NCH
// Notes:   one register stage; avgData is the pre-offset value used by calibration
`timescale 1ns/1ps
module aogc_corrector #(
   parameter int unsigned NCH = 3
)(
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   input  wire logic                          inValid,
   input  wire logic [aogc_pkg::CH_W-1:0]     inChan,
   input  wire logic [aogc_pkg::DATA_W-1:0]   inData,
   input  wire logic                          chop,
   input  wire logic                          offsetBinary,
   input  wire logic [aogc_pkg::COEF_W-1:0]   offsetCoef,
   input  wire logic [aogc_pkg::COEF_W-1:0]   gainCoef,
   output logic                               outValid,
   output logic [aogc_pkg::CH_W-1:0]          outChan,
   output logic [aogc_pkg::RES_W-1:0]         outData,
   output logic [aogc_pkg::DATA_W-1:0]        avgData
);
   import aogc_pkg::*;
   logic signed [DATA_W-1:0] prevReg [NCH];
   logic signed [DATA_W:0]   sum;
   logic signed [DATA_W-1:0] avg;
   logic signed [DATA_W+1:0] diff;
   logic signed [DATA_W+18:0] prod;
   logic signed [DATA_W+18:0] rnd;
   logic [RES_W-1:0]         clamped;

   function automatic logic [RES_W-1:0] clamp16(input logic signed [DATA_W+18:0] v);
      if (v > 43'sd32767)
         return 16'h7fff;
      else if (v < -43'sd32768)
         return 16'h8000;
      else
         return v[RES_W-1:0];
   endfunction

   always_comb begin
      sum     = {inData[DATA_W-1], inData} + {prevReg[inChan][DATA_W-1], prevReg[inChan]};
      avg     = chop ? sum[DATA_W:1] : inData;
      diff    = {{2{avg[DATA_W-1]}}, avg} - {{2{offsetCoef[COEF_W-1]}}, offsetCoef, 8'h00};
      prod    = diff * $signed({1'b0, gainCoef});
      rnd     = (prod + (43'sd1 <<< (ROUND_SHIFT - 1))) >>> ROUND_SHIFT;
      clamped = clamp16(rnd);
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int i = 0; i < NCH; i++) prevReg[i] <= '0;
      end else if (inValid) begin
         prevReg[inChan] <= inData;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         outValid <= 1'b0;
         outChan  <= '0;
         outData  <= '0;
         avgData  <= '0;
      end else begin
         outValid <= inValid;
         if (inValid) begin
            outChan <= inChan;
            outData <= {clamped[RES_W-1] ^ offsetBinary, clamped[RES_W-2:0]};
            avgData <= avg;
         end
      end
   end
endmodule // aogc_corrector

// ### hdl/aogc_gain_div.sv
// Purpose: derives a gain coefficient as full scale over measured span
// Assumes: start is a single-cycle pulse while idle
// Notes:   one quotient bit per cycle; small or negative spans saturate
`timescale 1ns/1ps
module aogc_gain_div (
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   input  wire logic                          start,
   input  wire logic signed [aogc_pkg::DATA_W:0] span,
   output logic                               done,
   output logic [aogc_pkg::COEF_W-1:0]        quotient
);
   import aogc_pkg::*;
   localparam logic [38:0] NUMER = {1'b0, FULL_SCALE_CODE, 14'h0000};
   logic [38:0] remReg;
   logic [38:0] dvsReg;
   logic [14:0] qReg;
   logic [3:0]  cntReg;
   logic        busyReg;
   logic        satReg;
   logic        ge;
   logic [39:0] spanFull;

   assign ge       = remReg >= dvsReg;
   assign spanFull = {span[DATA_W-1:0], 16'h0000};

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         remReg  <= '0;
         dvsReg  <= '0;
         qReg    <= '0;
         cntReg  <= '0;
         busyReg <= 1'b0;
         satReg  <= 1'b0;
      end else if (start) begin
         remReg  <= NUMER;
         dvsReg  <= {span[DATA_W-1:0], 15'h0000};
         qReg    <= '0;
         cntReg  <= 4'hf;
         busyReg <= 1'b1;
         // the register is 16 bits, so a span too small cannot be represented
         satReg  <= span[DATA_W] || (spanFull <= {1'b0, NUMER});
      end else if (busyReg) begin
         if (ge) remReg <= remReg - dvsReg;
         dvsReg  <= dvsReg >> 1;
         qReg    <= {qReg[13:0], ge};
         cntReg  <= cntReg - 4'h1;
         busyReg <= cntReg != 4'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         done     <= 1'b0;
         quotient <= '0;
      end else begin
         done <= busyReg && cntReg == 4'h0;
         if (busyReg && cntReg == 4'h0)
            quotient <= satReg ? GAIN_SAT : {qReg, ge};
      end
   end
endmodule // aogc_gain_div

// ### hdl/aogc_top.sv
// Purpose: result correction and automatic offset/gain calibration control
// Assumes: filter words arrive as single-cycle valid pulses with a channel index
// Notes:   registers reached over a plain strobe port, read data one cycle later
// Operation
// - average filter output when chopping
// - subtract channel offset before gain
// - multiply by channel gain coefficient
// - round to 16 bits, clamp, format
// - per-channel coefficients with factory reset values
// - coefficient writes only accepted while idle
// - calibration mode code starts automatic cycle
// - self calibration uses internal zero/full-scale
// - system calibration uses the external input
// - offset calibration three or two periods
// - gain calibration two stages, twice long
// - starting calibration aborts running conversion
// - single mode runs at programmed rate, then idle
// - filter control bit 15 enables chopping
// - gain coefficient exactly sixteen bits
// - reading channel 0 result clears flags
`timescale 1ns/1ps
module aogc_top #(
   parameter int unsigned NCH            = 3,
   parameter logic [15:0] FACTORY_OFFSET = 16'h0000,
   parameter logic [15:0] FACTORY_GAIN   = 16'h4000,
   parameter logic [2:0]  MODE_OFF       = 3'h0,
   parameter logic [2:0]  MODE_CONT      = 3'h1,
   parameter logic [2:0]  MODE_SINGLE    = 3'h2,
   parameter logic [2:0]  MODE_IDLE      = 3'h3,
   parameter logic [2:0]  MODE_SELF_OFF  = 3'h4,
   parameter logic [2:0]  MODE_SELF_GAIN = 3'h5,
   parameter logic [2:0]  MODE_SYS_OFF   = 3'h6,
   parameter logic [2:0]  MODE_SYS_GAIN  = 3'h7
)(
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   input  wire logic [aogc_pkg::ADDR_W-1:0]   regAddr,
   input  wire logic [31:0]                   regWrData,
   input  wire logic                          regWr,
   input  wire logic                          regRd,
   output logic [31:0]                        regRdData,
   input  wire logic                          filtValid,
   input  wire logic [aogc_pkg::CH_W-1:0]     filtChan,
   input  wire logic [aogc_pkg::DATA_W-1:0]   filtData,
   output logic                               converterEnable,
   output logic                               chopEnable,
   output logic [aogc_pkg::SF_W-1:0]          rateSelect,
   output logic [1:0]                         calInput,
   output logic                               convAbort,
   output logic                               calBusy
);
   import aogc_pkg::*;

   generate
      if (NCH < 1 || NCH > MAX_CH) begin : g_bad_nch
         $error("aogc_top: NCH out of range");
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////////////
   logic [MODE_W-1:0]  modeReg;
   logic [CH_W-1:0]    calChanReg;
   logic [FLT_W-1:0]   filterReg;
   logic [NCH-1:0]     readyReg;
   logic [NCH-1:0]     readySet;
   logic [RES_W-1:0]   resultReg [NCH];
   logic [COEF_W-1:0]  offsetReg [NCH];
   logic [COEF_W-1:0]  gainReg   [NCH];
   aogc_cal_e          calState;
   logic [2:0]         calCount;
   logic [2:0]         calTarget;
   logic               calGain;
   logic               calSelf;
   logic               abortReg;

   logic               chanOk;
   logic               corrValid;
   logic [CH_W-1:0]    corrChan;
   logic [RES_W-1:0]   corrData;
   logic [DATA_W-1:0]  corrAvg;
   logic               wrMode;
   logic               calStart;
   logic               calHit;
   logic               capture;
   logic               convOn;
   logic               rdClear;
   logic               divDone;
   logic [COEF_W-1:0]  divQuot;
   logic signed [DATA_W:0] gainSpan;
   logic [COEF_W-1:0]  curOffset;
   logic [COEF_W-1:0]  curGain;

   // codes as parameters, any encoding served
   function automatic logic isCal(input logic [MODE_W-1:0] m);
      return m == MODE_SELF_OFF || m == MODE_SELF_GAIN || m == MODE_SYS_OFF || m == MODE_SYS_GAIN;
   endfunction

   function automatic logic hitIdx(input logic [ADDR_W-1:0] a, input logic [7:0] base, input int unsigned i);
      return a == 8'(base + 8'(i) * REG_STRIDE);
   endfunction

   //////////////////////////////////////////////////////////////////////////////
   assign chanOk    = 32'(filtChan) < NCH;
   assign curOffset = chanOk ? offsetReg[filtChan] : '0;
   assign curGain   = chanOk ? gainReg[filtChan] : '0;
   assign wrMode    = regWr && regAddr == REG_MODE;
   assign calStart  = wrMode && calState == CAL_IDLE && isCal(regWrData[MODE_W-1:0]);
   assign calHit    = corrValid && corrChan == calChanReg;
   assign capture   = calState == CAL_MEAS && calHit && calCount == calTarget - 3'h1;
   assign convOn    = (modeReg == MODE_CONT || modeReg == MODE_SINGLE) && calState == CAL_IDLE;
   assign rdClear   = regRd && regAddr == REG_RESULT;
   // span against the stored cal-channel offset
   assign gainSpan  = {corrAvg[DATA_W-1], corrAvg}
                    - {offsetReg[calChanReg][COEF_W-1], offsetReg[calChanReg], 8'h00};

   assign converterEnable = modeReg != MODE_OFF;
   assign chopEnable      = filterReg[FLT_CHOP_BIT];
   assign rateSelect      = filterReg[SF_W-1:0];
   assign calBusy         = calState != CAL_IDLE;
   assign convAbort       = abortReg;

   //////////////////////////////////////////////////////////////////////////////
   // out-of-range channels never enter
   aogc_corrector #(
      .NCH          (NCH)
   ) u_corr (
      .clk          (clk),
      .reset_n      (reset_n),
      .inValid      (filtValid && chanOk),
      .inChan       (filtChan),
      .inData       (filtData),
      .chop         (filterReg[FLT_CHOP_BIT]),
      .offsetBinary (filterReg[FLT_OBIN_BIT]),
      .offsetCoef   (curOffset),
      .gainCoef     (curGain),
      .outValid     (corrValid),
      .outChan      (corrChan),
      .outData      (corrData),
      .avgData      (corrAvg)
   );

   // fed only by the last gain-stage word
   aogc_gain_div u_div (
      .clk      (clk),
      .reset_n  (reset_n),
      .start    (capture && calGain),
      .span     (gainSpan),
      .done     (divDone),
      .quotient (divQuot)
   );

   //////////////////////////////////////////////////////////////////////////////
   // mode writes are ignored while a calibration runs
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         modeReg    <= MODE_RST;
         calChanReg <= '0;
      end else if ((capture && !calGain) || (calState == CAL_DIV && divDone)) begin
         modeReg <= MODE_IDLE;
      end else if (wrMode && calState == CAL_IDLE) begin
         modeReg    <= regWrData[MODE_W-1:0];
         calChanReg <= regWrData[CAL_CHAN_LSB +: CH_W];
      end else if (modeReg == MODE_SINGLE && corrValid && convOn) begin
         modeReg <= MODE_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n)
         filterReg <= FILTER_RST;
      else if (regWr && regAddr == REG_FILTER)
         filterReg <= regWrData[FLT_W-1:0];
   end

   always_ff @(posedge clk) begin
      if (!reset_n)
         abortReg <= 1'b0;
      else
         // only when a conversion was running
         abortReg <= calStart && convOn;
   end

   //////////////////////////////////////////////////////////////////////////////
   // period count is latched at start so a chop change mid-cycle cannot stretch it
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         calState  <= CAL_IDLE;
         calCount  <= '0;
         calTarget <= '0;
         calGain   <= 1'b0;
         calSelf   <= 1'b0;
      end else begin
         case (calState)
            CAL_IDLE: begin
               if (calStart) begin
                  calState <= CAL_MEAS;
                  calCount <= '0;
                  calGain  <= regWrData[MODE_W-1:0] == MODE_SELF_GAIN
                           || regWrData[MODE_W-1:0] == MODE_SYS_GAIN;
                  calSelf  <= regWrData[MODE_W-1:0] == MODE_SELF_OFF
                           || regWrData[MODE_W-1:0] == MODE_SELF_GAIN;
                  calTarget <= (filterReg[FLT_CHOP_BIT] ? PERIODS_CHOP : PERIODS_NOCHOP)
                            << ((regWrData[MODE_W-1:0] == MODE_SELF_GAIN
                                 || regWrData[MODE_W-1:0] == MODE_SYS_GAIN) ? 1 : 0);
               end
            end
            CAL_MEAS: begin
               if (calHit)
                  calCount <= calCount + 3'h1;
               if (capture)
                  calState <= calGain ? CAL_DIV : CAL_IDLE;
            end
            CAL_DIV: begin
               if (divDone)
                  calState <= CAL_IDLE;
            end
            default: calState <= CAL_IDLE;
         endcase
      end
   end

   // self cycles pick an internal reference
   always_comb begin
      calInput = INSEL_EXT;
      if (calState != CAL_IDLE && calSelf)
         calInput = calGain ? INSEL_FULL : INSEL_ZERO;
   end

   //////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int i = 0; i < NCH; i++) begin
            offsetReg[i] <= FACTORY_OFFSET;
            gainReg[i]   <= FACTORY_GAIN;
         end
      end else begin
         // cal result beats a same-cycle write
         for (int i = 0; i < NCH; i++) begin
            if (capture && !calGain && 32'(calChanReg) == i)
               offsetReg[i] <= corrAvg[DATA_W-1:OFFSET_SHIFT];
            else if (regWr && modeReg == MODE_IDLE && hitIdx(regAddr, REG_OFFSET, i))
               offsetReg[i] <= regWrData[COEF_W-1:0];
            if (calState == CAL_DIV && divDone && 32'(calChanReg) == i)
               gainReg[i] <= divQuot;
            else if (regWr && modeReg == MODE_IDLE && hitIdx(regAddr, REG_GAIN, i))
               gainReg[i] <= regWrData[COEF_W-1:0];
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // a result register holds until software reads the channel 0 result; new words are dropped meanwhile
   always_comb begin
      readySet = '0;
      for (int i = 0; i < NCH; i++)
         readySet[i] = corrValid && convOn && 32'(corrChan) == i && !readyReg[i];
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int i = 0; i < NCH; i++) resultReg[i] <= '0;
      end else begin
         for (int i = 0; i < NCH; i++)
            if (readySet[i]) resultReg[i] <= corrData;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n)
         readyReg <= '0;
      else
         // channel-0 result read clears all
         readyReg <= (readyReg & ~{NCH{rdClear}}) | readySet;
   end

   //////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         regRdData <= '0;
      end else begin
         // unmapped or idle reads give zero
         regRdData <= '0;
         if (regRd) begin
            if (regAddr == REG_MODE)
               regRdData <= {26'h0, calChanReg, 1'b0, modeReg};
            else if (regAddr == REG_FILTER)
               regRdData <= {16'h0, filterReg};
            else if (regAddr == REG_FLAGS)
               regRdData <= {23'h0, calBusy, 8'(readyReg)};
            for (int i = 0; i < NCH; i++) begin
               if (hitIdx(regAddr, REG_RESULT, i)) regRdData <= {16'h0, resultReg[i]};
               if (hitIdx(regAddr, REG_OFFSET, i)) regRdData <= {16'h0, offsetReg[i]};
               if (hitIdx(regAddr, REG_GAIN, i))   regRdData <= {16'h0, gainReg[i]};
            end
         end
      end
   end
endmodule // aogc_top

// ### verif/aogc_props.sv
// Purpose: port assertions for aogc_top
// Assumes: calibration codes 4..7 as in the defaults
// Notes:   bound to every aogc_top instance
`timescale 1ns/1ps
module aogc_props #(
   parameter int unsigned NCH = 3
)(
   input wire logic                        clk,
   input wire logic                        reset_n,
   input wire logic [aogc_pkg::ADDR_W-1:0] regAddr,
   input wire logic [31:0]                 regWrData,
   input wire logic                        regWr,
   input wire logic                        converterEnable,
   input wire logic                        chopEnable,
   input wire logic [aogc_pkg::SF_W-1:0]   rateSelect,
   input wire logic [1:0]                  calInput,
   input wire logic                        convAbort,
   input wire logic                        calBusy
);
   import aogc_pkg::*;
   wire logic fw = regWr && regAddr == REG_FILTER;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////
   property p_chop; fw |=> chopEnable == $past(regWrData[15]); endproperty
   a_chop: assert property (p_chop) else $error("chop bit not taken");
   property p_rate; fw |=> rateSelect == $past(regWrData[6:0]); endproperty
   a_rate: assert property (p_rate) else $error("rate not taken");
   property p_start; $rose(calBusy) |-> $past(regWr) && $past(regAddr) == REG_MODE && $past(regWrData[2]); endproperty
   a_start: assert property (p_start) else $error("busy without start");
   property p_self; $rose(calBusy) && !$past(regWrData[1]) |-> calInput == ($past(regWrData[0]) ? INSEL_FULL : INSEL_ZERO);
   endproperty
   a_self: assert property (p_self) else $error("self input wrong");
   property p_sys; $rose(calBusy) && $past(regWrData[1]) |-> calInput == INSEL_EXT; endproperty
   a_sys: assert property (p_sys) else $error("system input wrong");
   property p_hold; calBusy && $past(calBusy) |-> $stable(calInput); endproperty
   a_hold: assert property (p_hold) else $error("input moved");
   property p_free; !calBusy |-> calInput == INSEL_EXT; endproperty
   a_free: assert property (p_free) else $error("input not released");
   property p_abort; convAbort |-> calBusy ##1 !convAbort; endproperty
   a_abort: assert property (p_abort) else $error("abort pulse wrong");
   property p_end; $fell(calBusy) |-> converterEnable; endproperty
   a_end: assert property (p_end) else $error("not idle after cal");
endmodule // aogc_props
bind aogc_top aogc_props #(.NCH(NCH)) u_props (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
   .regWrData(regWrData), .regWr(regWr), .converterEnable(converterEnable), .chopEnable(chopEnable),
   .rateSelect(rateSelect), .calInput(calInput), .convAbort(convAbort), .calBusy(calBusy));

// ### verif/aogc_filter_model.sv
// Purpose: modulator and decimation filter stand-in
// Assumes: one word per request, lag plus one cycles after the request is sampled
// Notes:   data line scrambles between words
`timescale 1ns/1ps
module aogc_filter_model #(
   parameter logic [23:0] ZERO_IN = 24'h001200,
   parameter logic [23:0] FULL_IN = 24'h600000
)(
   input wire logic  clk,
   input wire logic  req,
   input wire logic  [5:0] lag,
   input wire logic  [1:0] chan,
   input wire logic  [23:0] ext,
   input wire logic  [1:0] calInput,
   output logic      filtValid = 1'b0,
   output logic      [1:0] filtChan = 2'h0,
   output logic      [23:0] filtData = 24'h0
);
   logic [6:0] cnt = 7'h0;
   always @(posedge clk) begin
      filtValid <= 1'b0;
      filtData <= ~filtData; // no stale value between words
      if (cnt == 7'h1) begin
         filtValid <= 1'b1;
         filtChan <= chan;
         filtData <= calInput == 2'h1 ? ZERO_IN : calInput == 2'h2 ? FULL_IN : ext;
      end
      if (req) cnt <= {1'b0, lag} + 7'h1;
      else if (cnt != 7'h0) cnt <= cnt - 7'h1;
   end
endmodule // aogc_filter_model

// ### verif/tb_adc_offset_gain_calibration.sv
// Purpose: self-checking bench for aogc_top
// Assumes: default mode codes and factory values
// Notes:   long waits come from the 23us mode rule
`timescale 1ns/1ps
module tb_adc_offset_gain_calibration;
   import aogc_pkg::*;
   localparam logic [23:0] ZERO_IN = 24'h001200;
   localparam logic [23:0] FULL_IN = 24'h600000;
   logic        clk = 1'b0, reset_n = 1'b0, regWr = 1'b0, regRd = 1'b0, req = 1'b0, abortSeen = 1'b0;
   logic [7:0]  regAddr = 8'h0;
   logic [31:0] regWrData = 32'h0, regRdData, d;
   logic [1:0]  filtChan, calInput, chan = 2'h0;
   logic [23:0] filtData, ext = 24'h0, prevExt;
   logic [15:0] lf = 16'h002a, offv, g;
   logic [6:0]  rateSelect;
   logic [5:0]  lag = 6'h0;
   logic        filtValid, converterEnable, chopEnable, convAbort, calBusy;
   longint      x;
   int          fail_count = 0, compares = 0, n, cnt;
   aogc_top dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .filtValid(filtValid), .filtChan(filtChan), .filtData(filtData),
      .converterEnable(converterEnable), .chopEnable(chopEnable), .rateSelect(rateSelect),
      .calInput(calInput), .convAbort(convAbort), .calBusy(calBusy));
   aogc_filter_model #(.ZERO_IN(ZERO_IN), .FULL_IN(FULL_IN)) far (.clk(clk), .req(req), .lag(lag),
      .chan(chan), .ext(ext), .calInput(calInput), .filtValid(filtValid), .filtChan(filtChan), .filtData(filtData));
   always #2 clk = ~clk;
   always @(posedge clk) if (convAbort === 1'b1) abortSeen <= 1'b1;
   ////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [31:0] corr(input longint v, input logic [15:0] o, k, input logic ob);
      longint y;
      y = ((v - longint'($signed(o)) * 256) * longint'(k) + (64'sd1 <<< 21)) >>> 22;
      if (y > 32767) y = 32767;
      if (y < -32768) y = -32768;
      return {16'h0, y[15] ^ ob, y[14:0]};
   endfunction
   task chk(input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      regAddr <= a;
      regWrData <= v;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 v = regRdData;
   endtask
   task word(input logic [5:0] l);
      int i;
      @(posedge clk);
      req <= 1'b1;
      lag <= l;
      @(posedge clk);
      req <= 1'b0;
      for (i = 0; i < 70 && filtValid !== 1'b1; i++) @(posedge clk);
      repeat (24) @(posedge clk); // covers divider time
   endtask
   task wait23;
      repeat (5750) @(posedge clk);
   endtask
   task test_done;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      #300000;
      fail_count++;
      $display("BAD %0t watchdog expired", $time);
      test_done;
   end
   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      for (n = 0; n < 3; n++) begin
         rd(REG_OFFSET + 8'(n * 4), d);
         chk(d, 32'h0);
         rd(REG_GAIN + 8'(n * 4), d);
         chk(d, 32'h4000);
      end
      rd(8'hfc, d);
      chk(d, 32'h0);
      wr(REG_OFFSET + 8'h04, 32'h1234);
      rd(REG_OFFSET + 8'h04, d);
      chk(d, 32'h0);
      wr(REG_MODE, 32'h3);
      wr(REG_OFFSET + 8'h04, 32'h1234);
      rd(REG_OFFSET + 8'h04, d);
      chk(d, 32'h1234);
      wait23;
      $display("reset and access test done");
      for (n = 0; n < 4; n++) begin
         lf = lfsr(lf);
         offv = {8'h0, lf[15:8]};
         g = {lf[1:0], 14'h0};
         wr(REG_MODE, 32'h3);
         wr(REG_OFFSET, {16'h0, offv});
         wr(REG_GAIN, {16'h0, g});
         wr(REG_FILTER, {16'h0, n == 2, n == 3, 7'h0, lf[6:0]});
         wait23;
         chk({25'h0, rateSelect}, {25'h0, lf[6:0]});
         chk({31'h0, chopEnable}, {31'h0, n == 2});
         wr(REG_MODE, n == 1 ? 32'h2 : 32'h1);
         lf = lfsr(lf);
         prevExt = ext;
         ext = {lf[14:0], 9'h0};
         word(lf[5:0]);
         x = longint'($signed(ext));
         if (n == 2) x = (x + longint'($signed(prevExt))) / 2;
         rd(REG_RESULT, d);
         chk(d, corr(x, offv, g, n == 3));
         rd(REG_FLAGS, d);
         chk(d, 32'h0);
         rd(REG_MODE, d);
         chk(d, n == 1 ? 32'h3 : 32'h1);
      end
      $display("result path test done");
      chan = 2'h1;
      for (n = 4; n < 8; n++) begin
         wr(REG_MODE, 32'h3);
         if (n[0] == 1'b0) wr(REG_OFFSET + 8'h04, 32'h0);
         if (n[0] == 1'b0) offv = 16'h0;
         wr(REG_GAIN + 8'h04, 32'h4000);
         wr(REG_FILTER, {16'h0, n[1], 8'h0, 7'h7f});
         wait23;
         if (n == 4) wr(REG_MODE, 32'h1);
         ext = n[0] ? 24'h500000 : 24'hfff800;
         abortSeen = 1'b0;
         wr(REG_MODE, {26'h0, 2'h1, 1'b0, n[2:0]});
         wr(REG_OFFSET + 8'h08, 32'hbeef);
         cnt = 0;
         while (calBusy === 1'b1 && cnt < 8) begin
            word(6'(cnt * 5));
            cnt++;
         end
         chk(32'(cnt), (n[1] ? 32'd2 : 32'd3) * (n[0] ? 32'd2 : 32'd1));
         chk({31'h0, abortSeen}, {31'h0, n == 4});
         rd(REG_MODE, d);
         chk({29'h0, d[2:0]}, 32'h3);
         x = longint'($signed(n[1] ? ext : (n[0] ? FULL_IN : ZERO_IN)));
         if (n[0]) begin
            rd(REG_GAIN + 8'h04, d);
            chk(d, 32'((64'h7fffff << 14) / (x - longint'($signed(offv)) * 256)));
         end else begin
            offv = x[23:8];
            rd(REG_OFFSET + 8'h04, d);
            chk(d, {16'h0, offv});
         end
      end
      rd(REG_OFFSET + 8'h08, d);
      chk(d, 32'h0);
      $display("calibration test done");
      test_done;
   end
endmodule // tb_adc_offset_gain_calibration
